// ---- verilog/wl_ctrl.sv ----
`timescale 1ns/1ps
`include "wl_params.svh"

module wl_ctrl
    import wl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    wl_link_if.ctl link,
    input wire logic start,
    input wire logic qoff_in,
    input wire logic lat_up,
    input wire logic dll_on,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [1:0] locked,
    output logic [5:0] taps
);

    // ***********************************************************
    // link clock divider
    // ***********************************************************
    logic [2:0] div;
    logic ck_q;
    logic ck_o;

    wire div_end = (div == `WL_DIV_END);
    wire rise = div_end & ~ck_q;
    wire fall = div_end & ck_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div <= 3'h0;
            ck_q <= 1'b0;
        end else begin
            div <= div_end ? 3'h0 : div + 3'h1;
            ck_q <= ck_q ^ div_end;
        end
    end

    // half a clk late so strobe edges never coincide with clock edges
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            ck_o <= 1'b0;
        end else begin
            ck_o <= ck_q;
        end
    end

    // ***********************************************************
    // sequence state
    // ***********************************************************
    wl_state_t st;
    wl_state_t next_st;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic mode_register_set_command;
    logic next_mrs;
    logic [2:0] ba;
    logic [2:0] next_ba;
    logic [13:0] addr;
    logic [13:0] next_addr;
    logic termination_control_pin;
    logic next_odt;
    logic oe;
    logic next_oe;
    logic next_done;
    logic next_fail;
    logic [3:0] dly;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic [1:0] lock_now;
    logic [1:0] tap_end;
    logic [1:0] hi;

    wire cnt_zero = (cnt == 8'h00);
    wire all_lock = &lock_now;
    wire any_end = |(tap_end & ~lock_now);
    wire [13:0] lvl_mask = 14'h0001 << `WL_LVL_BIT;
    wire [13:0] qoff_mask = 14'h0001 << `WL_QOFF_BIT;
    wire [13:0] mr1_on = `WL_MR1_BASE | lvl_mask | (qoff_in ? qoff_mask : 14'h0);
    wire [7:0] mod_wait = lat_up ? `WL_MODE_UPDATE_DELAY_NCK + `WL_ODTLON_NCK : `WL_MODE_UPDATE_DELAY_NCK;
    wire [7:0] dqsen_wait = dll_on ? `WL_DQSEN_DLL - `WL_MODE_UPDATE_DELAY_NCK
                                   : `WL_DQSEN_NODLL - `WL_MODE_UPDATE_DELAY_NCK;

    // next state and command bus; commands change on the falling tick
    always_comb begin
        next_st = st;
        next_cnt = (rise && !cnt_zero) ? cnt - 8'h01 : cnt;
        next_mrs = fall ? 1'b0 : mode_register_set_command;
        next_ba = ba;
        next_addr = addr;
        next_odt = termination_control_pin;
        next_oe = oe;
        next_done = done;
        next_fail = fail;
        unique case (st)
            S_IDLE: begin
                if (start) begin
                    next_st = S_MR2;
                    next_done = 1'b0;
                    next_fail = 1'b0;
                end
            end
            S_MR2: begin
                if (fall) begin
                    next_mrs = 1'b1;
                    next_ba = `WL_MR2_IDX;
                    next_addr = `WL_MR2_VAL;
                    next_cnt = `WL_MODE_REGISTER_CYCLE_TIME_NCK;
                    next_st = S_W_MRD;
                end
            end
            S_W_MRD: begin
                if (cnt_zero) begin
                    next_st = S_MR1_ON;
                end
            end
            S_MR1_ON: begin
                if (fall) begin
                    next_mrs = 1'b1;
                    next_ba = `WL_MR1_IDX;
                    next_addr = mr1_on;
                    next_cnt = mod_wait;
                    next_st = S_W_MOD;
                end
            end
            S_W_MOD: begin
                if (cnt_zero && fall) begin
                    next_odt = 1'b1;
                    next_cnt = dqsen_wait;
                    next_st = S_W_DQSEN;
                end
            end
            S_W_DQSEN: begin
                if (cnt_zero) begin
                    next_oe = 1'b1;
                    next_cnt = `WL_FIRST_NCK;
                    next_st = S_W_FIRST;
                end
            end
            S_W_FIRST: begin
                if (cnt_zero) begin
                    next_st = qoff_in ? S_STOP : S_ALIGN;
                end
            end
            S_ALIGN: begin
                if (fall) begin
                    next_st = S_PULSE;
                end
            end
            S_PULSE: begin
                if (dly == `WL_PULSE_END) begin
                    next_cnt = `WL_FEEDBACK_OUTPUT_DELAY_NCK;
                    next_st = S_W_FB;
                end
            end
            S_W_FB: begin
                if (cnt_zero) begin
                    next_st = S_SAMPLE;
                end
            end
            S_SAMPLE: begin
                next_fail = ~all_lock & any_end;
                next_st = (all_lock || any_end) ? S_STOP : S_ALIGN;
            end
            S_STOP: begin
                next_oe = 1'b0;
                if (fall) begin
                    next_odt = 1'b0;
                    next_cnt = `WL_ODTOFF_NCK;
                    next_st = S_W_ODT;
                end
            end
            S_W_ODT: begin
                if (cnt_zero) begin
                    next_st = S_MR1_OFF;
                end
            end
            S_MR1_OFF: begin
                if (fall) begin
                    next_mrs = 1'b1;
                    next_ba = `WL_MR1_IDX;
                    next_addr = `WL_MR1_BASE;
                    next_cnt = `WL_MODE_UPDATE_DELAY_NCK;
                    next_st = S_W_END;
                end
            end
            S_W_END: begin
                if (cnt_zero) begin
                    next_done = 1'b1;
                    next_st = S_IDLE;
                end
            end
        endcase
    end

    // sequence registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= S_IDLE;
            cnt <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            busy <= (next_st != S_IDLE);
            done <= next_done;
            fail <= next_fail;
        end
    end

    // command bus and pin registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_register_set_command <= 1'b0;
            ba <= 3'h0;
            addr <= 14'h0000;
            termination_control_pin <= 1'b0;
            oe <= 1'b0;
        end else begin
            mode_register_set_command <= next_mrs;
            ba <= next_ba;
            addr <= next_addr;
            termination_control_pin <= next_odt;
            oe <= next_oe;
        end
    end

    // ***********************************************************
    // strobe delay line and feedback capture
    // ***********************************************************
    // clk steps after the clock fall, so the sweep spans the next rise
    always_ff @(posedge clk) begin
        if (!rst_n || st == S_ALIGN) begin
            dly <= 4'h0;
        end else if (st == S_PULSE) begin
            dly <= dly + 4'h1;
        end
    end

    // feedback crosses from the pins through two flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
        end else begin
            dq_s1 <= link.dq;
            dq_s2 <= dq_s1;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : lane
        wl_tap_t tap;
        logic prev;
        logic lk;
        logic dqs_t_q;
        logic dqs_c_q;
        wire fb = dq_s2[8 * g];
        wire [4:0] tap5 = {2'b00, tap};
        wire [4:0] dly5 = {1'b0, dly};

        // one high pulse of fixed width at the lane's tap
        assign hi[g] = (st == S_PULSE) && (dly5 >= tap5) &&
                       (dly5 < tap5 + `WL_DQSH_CLK);
        assign lock_now[g] = lk | (~prev & fb);
        assign tap_end[g] = (tap == `WL_TAP_MAX);

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                dqs_t_q <= 1'b0;
                dqs_c_q <= 1'b1;
            end else begin
                dqs_t_q <= hi[g];
                dqs_c_q <= ~hi[g];
            end
        end

        // lock on a low then high reading, else step the delay up until the last tap
        always_ff @(posedge clk) begin
            if (!rst_n || (st == S_IDLE && start)) begin
                tap <= 3'h0;
                prev <= 1'b1;
                lk <= 1'b0;
            end else if (st == S_SAMPLE && !lk) begin
                prev <= fb;
                lk <= lock_now[g];
                if (!lock_now[g] && !tap_end[g]) begin
                    tap <= tap + 3'h1;
                end
            end
        end

        assign link.dqs_t_o[g] = dqs_t_q;
        assign link.dqs_c_o[g] = dqs_c_q;
        assign locked[g] = lk;
        assign taps[3 * g +: 3] = tap;
    end

    assign link.ck = ck_o;
    assign link.cmd_mrs = mode_register_set_command;
    assign link.cmd_ba = ba;
    assign link.cmd_addr = addr;
    assign link.termination_control_pin = termination_control_pin;
    assign link.dqs_oe = {2{oe}};

endmodule

// ---- inc/wl_params.svh ----
`ifndef WL_PARAMS_SVH
`define WL_PARAMS_SVH

// ***********************************************************
// mode register layout
// ***********************************************************
`define WL_MR1_IDX 3'h1
`define WL_MR2_IDX 3'h2
`define WL_LVL_BIT 4'h7
`define WL_QOFF_BIT 4'hC
`define WL_MR1_RST 14'h0000
`define WL_MR1_BASE 14'h0000
`define WL_MR2_VAL 14'h0000

// ***********************************************************
// link timing, in link clock cycles
// ***********************************************************
`define WL_MODE_UPDATE_DELAY_NCK 8'h18
`define WL_MODE_REGISTER_CYCLE_TIME_NCK 8'h08
`define WL_ODTLON_NCK 8'h0A
`define WL_TERMINATION_SWITCH_TIME_NCK 8'h02
`define WL_ASYNC_TERMINATION_ON_TIME_NCK 8'h02
`define WL_STROBE_LOW_WIDTH_NCK 8'h02
`define WL_FIRST_STROBE_DELAY_NCK 8'h28
`define WL_FEEDBACK_OUTPUT_DELAY_NCK 8'h06
`define WL_ODTOFF_NCK 8'h0C
`define WL_DQSEN_DLL (`WL_MODE_UPDATE_DELAY_NCK + `WL_ODTLON_NCK + `WL_TERMINATION_SWITCH_TIME_NCK + 8'h01)
`define WL_DQSEN_NODLL (`WL_MODE_UPDATE_DELAY_NCK + `WL_ASYNC_TERMINATION_ON_TIME_NCK + 8'h01)
`define WL_FIRST_NCK ((`WL_STROBE_LOW_WIDTH_NCK > `WL_FIRST_STROBE_DELAY_NCK) ? `WL_STROBE_LOW_WIDTH_NCK : `WL_FIRST_STROBE_DELAY_NCK)

// ***********************************************************
// controller clock divider and strobe delay line, in clk cycles
// ***********************************************************
`define WL_DIV_END 3'h3
`define WL_TAP_MAX 3'h7
`define WL_DQSH_CLK 5'h04
`define WL_PULSE_END 4'hB

`endif

// ---- inc/wl_pkg.sv ----
package wl_pkg;

    // controller sequence states
    typedef enum logic [3:0] {
        S_IDLE, S_MR2, S_W_MRD, S_MR1_ON, S_W_MOD, S_W_DQSEN, S_W_FIRST,
        S_ALIGN, S_PULSE, S_W_FB, S_SAMPLE, S_STOP, S_W_ODT, S_MR1_OFF,
        S_W_END
    } wl_state_t;

    typedef logic [2:0] wl_tap_t;

endpackage

// ---- inc/wl_link_if.sv ----
`timescale 1ns/1ps

interface wl_link_if;
    logic ck;
    logic cmd_mrs;
    logic [2:0] cmd_ba;
    logic [13:0] cmd_addr;
    logic termination_control_pin;
    logic [1:0] dqs_t_o;
    logic [1:0] dqs_c_o;
    logic [1:0] dqs_oe;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [1:0] dqs_t;
    logic [1:0] dqs_c;
    logic [15:0] dq;

    // wire levels: an undriven line reads low
    assign dqs_t = dqs_t_o & dqs_oe;
    assign dqs_c = dqs_c_o & dqs_oe;
    assign dq = dq_o & dq_oe;

    modport dev (
        input ck, cmd_mrs, cmd_ba, cmd_addr, termination_control_pin, dqs_t, dqs_c,
        output dq_o, dq_oe
    );
    modport ctl (
        output ck, cmd_mrs, cmd_ba, cmd_addr, termination_control_pin, dqs_t_o, dqs_c_o,
        output dqs_oe,
        input dq
    );
endinterface

// ---- verilog/wl_dram.sv ----
`timescale 1ns/1ps
`include "wl_params.svh"

module wl_dram
    import wl_pkg::*;
(
    wl_link_if.dev link,
    input wire logic rst_n,
    input wire logic nom_en,
    input wire logic park_en,
    output logic lvl,
    output logic qoff,
    output logic dqs_term,
    output logic dq_term
);

    // ***********************************************************
    // command and termination pin capture
    // ***********************************************************
    logic [18:0] cs1;
    logic [18:0] cs2;
    logic [13:0] mr1;
    logic [7:0] mod_cnt;
    logic [1:0] seen_s1;
    logic [1:0] seen_s2;
    logic [1:0] oe_q;
    logic [1:0] samp_v;
    logic [1:0] seen_v;

    wire [18:0] cmd_raw = {link.termination_control_pin, link.cmd_mrs, link.cmd_ba, link.cmd_addr};
    wire odt_s = cs2[18];
    wire mrs_mr1 = cs2[17] && (cs2[16:14] == `WL_MR1_IDX);
    wire odt_ok = (mod_cnt == 8'h00);
    wire term_sel = odt_s ? nom_en : park_en;

    // two flops on every command and termination pin from the controller
    always_ff @(posedge link.ck) begin
        if (!rst_n) begin
            cs1 <= '0;
            cs2 <= '0;
        end else begin
            cs1 <= cmd_raw;
            cs2 <= cs1;
        end
    end

    // ***********************************************************
    // mode register one and mode update delay
    // ***********************************************************
    // a mode command loads all of mode register one at once
    always_ff @(posedge link.ck) begin
        if (!rst_n) begin
            mr1 <= `WL_MR1_RST;
        end else if (mrs_mr1) begin
            mr1 <= cs2[13:0];
        end
    end

    // termination pin is ignored until the update delay runs out
    always_ff @(posedge link.ck) begin
        if (!rst_n) begin
            mod_cnt <= 8'h00;
        end else if (mrs_mr1) begin
            mod_cnt <= `WL_MODE_UPDATE_DELAY_NCK;
        end else if (!odt_ok) begin
            mod_cnt <= mod_cnt - 8'h01;
        end
    end

    assign lvl = mr1[`WL_LVL_BIT];
    assign qoff = mr1[`WL_QOFF_BIT];

    // ***********************************************************
    // termination
    // ***********************************************************
    // in leveling only the strobes follow the pin, any setting allowed
    always_ff @(posedge link.ck) begin
        if (!rst_n) begin
            dqs_term <= 1'b0;
            dq_term <= 1'b0;
        end else begin
            dqs_term <= odt_ok & term_sel;
            dq_term <= odt_ok & term_sel & ~lvl;
        end
    end

    // ***********************************************************
    // per lane strobe sampling of the clock
    // ***********************************************************
    for (genvar g = 0; g < 2; g++) begin : lane
        logic samp;
        logic seen;
        // lane g strobe samples the clock level; cleared out of leveling
        always_ff @(posedge link.dqs_t[g] or negedge lvl) begin
            if (!lvl) begin
                samp <= 1'b0;
                seen <= 1'b0;
            end else begin
                samp <= link.ck;
                seen <= 1'b1;
            end
        end
        assign samp_v[g] = samp;
        assign seen_v[g] = seen;
    end

    // feedback enable: undriven until the first strobe edge was seen
    always_ff @(posedge link.ck) begin
        if (!rst_n) begin
            seen_s1 <= 2'h0;
            seen_s2 <= 2'h0;
            oe_q <= 2'h0;
        end else begin
            seen_s1 <= seen_v;
            seen_s2 <= seen_s1;
            oe_q <= seen_s2 & {2{lvl & ~qoff}};
        end
    end

    // feedback goes straight out with no read strobe
    assign link.dq_o = {{8{samp_v[1]}}, {8{samp_v[0]}}};
    assign link.dq_oe = {{8{oe_q[1]}}, {8{oe_q[0]}}};

endmodule

// ---- bench/wl_link_chk.sv ----
`timescale 1ns/1ps
`include "wl_params.svh"

module wl_link_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ck,
    input wire logic cmd_mrs,
    input wire logic [2:0] cmd_ba,
    input wire logic [13:0] cmd_addr,
    input wire logic termination_control_pin,
    input wire logic [1:0] dqs_oe,
    input wire logic [1:0] dqs_t,
    input wire logic [1:0] dqs_c,
    input wire logic [15:0] dq,
    input wire logic [15:0] dq_oe
);
    // **************************************************
    // helper state
    // **************************************************
    // counters start one edge after the command is sampled
    localparam int MOD_MIN = 23;
    localparam int OFF_MIN = 11;
    logic [7:0] mr1_cnt;
    logic [7:0] low_cnt;
    logic qoff_on;
    logic [1:0] seen;

    // command decode and next values
    wire mr1 = cmd_mrs && (cmd_ba == `WL_MR1_IDX);
    wire enter = mr1 && cmd_addr[`WL_LVL_BIT];
    wire leave = mr1 && !cmd_addr[`WL_LVL_BIT];
    wire [7:0] next_mr1_cnt = mr1 ? 8'h00 : mr1_cnt + {7'h00, mr1_cnt != 8'hFF};
    wire [7:0] next_low_cnt = termination_control_pin ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
    wire next_qoff_on = enter ? cmd_addr[`WL_QOFF_BIT] : (leave ? 1'b0 : qoff_on);
    wire [1:0] next_seen = mr1 ? 2'h0 : (seen | dqs_t);

    // link clock side bookkeeping
    // link clock stops in reset, so clear on the reset edge itself
    always_ff @(posedge ck or negedge rst_n) begin
        if (!rst_n) begin
            mr1_cnt <= 8'hFF;
            low_cnt <= 8'h00;
            qoff_on <= 1'b0;
        end else begin
            mr1_cnt <= next_mr1_cnt;
            low_cnt <= next_low_cnt;
            qoff_on <= next_qoff_on;
        end
    end

    // strobe edges seen since the last mode command
    always_ff @(posedge clk) begin
        seen <= rst_n ? next_seen : 2'h0;
    end

    // **************************************************
    // assertions
    // **************************************************
    chk_mrs_one_ck:
        assert property (@(posedge ck) disable iff (!rst_n)
        $rose(cmd_mrs) |=> !cmd_mrs) else $error("mode command too long");
    chk_mrs_gap:
        assert property (@(posedge ck) disable iff (!rst_n)
        $rose(cmd_mrs) |=> !cmd_mrs [*7]) else $error("mode commands too close");
    chk_odt_after_mod:
        assert property (@(posedge ck) disable iff (!rst_n)
        $rose(termination_control_pin) |-> mr1_cnt >= MOD_MIN) else $error("odt before update delay");
    chk_exit_order:
        assert property (@(posedge ck) disable iff (!rst_n)
        leave |-> !termination_control_pin && low_cnt >= OFF_MIN && dqs_oe == 2'h0)
        else $error("exit command out of order");
    chk_strobe_prep:
        assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dqs_oe[0]) |-> termination_control_pin && !dqs_t[0] && dqs_c[0])
        else $error("strobe not parked low");
    chk_pulse_width:
        assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dqs_t[0]) |-> dqs_t[0] [*4] ##1 !dqs_t[0])
        else $error("strobe pulse width wrong");
    chk_lane_level:
        assert property (@(posedge clk) disable iff (!rst_n)
        |dq_oe |-> dq_oe[7:0] inside {8'h00, 8'hFF}
        && dq[7:0] inside {8'h00, 8'hFF} && dq[15:8] inside {8'h00, 8'hFF})
        else $error("lane bits disagree");
    chk_qoff_silent:
        assert property (@(posedge ck) disable iff (!rst_n)
        qoff_on |-> dq_oe == 16'h0000) else $error("output off rank drives");
    chk_fb_after_dqs:
        assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dq_oe[0]) |-> seen[0]) else $error("feedback before strobe");

    // main scenarios reached
    cov_enter_qoff: cover property (@(posedge ck) enter && cmd_addr[12]);
    cov_feedback: cover property (@(posedge clk) $rose(dq_oe[8]));
    cov_exit: cover property (@(posedge ck) leave);
endmodule

// ---- bench/write_leveling_mode_test.sv ----
`timescale 1ns/1ps

module write_leveling_mode_test import wl_pkg::*;;
    typedef struct packed {
        logic qoff;
        logic lat;
        logic dll;
        logic nom;
        logic park;
        logic [1:0] lock;
    } wl_row_t;

    // **************************************************
    // stimulus, design and checker
    // **************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dev_rst_n = 1'b0;
    logic start = 1'b0;
    logic qoff_in = 1'b0;
    logic lat_up = 1'b0;
    logic dll_on = 1'b0;
    logic nom_en = 1'b0;
    logic park_en = 1'b0;
    logic busy, done, fail, lvl, qoff, dqs_term, dq_term;
    logic [1:0] locked;
    logic [5:0] taps;
    logic [1:0] smp0 = 2'h0;
    logic [1:0] smp1 = 2'h0;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    wl_row_t rows [5] = '{7'h1B, 7'h27, 7'h7C, 7'h3F, 7'h40};

    always #2.5 clk = ~clk;

    wl_link_if i_wl_link_if ();

    wl_ctrl i_wl_ctrl (.clk(clk), .rst_n(rst_n), .link(i_wl_link_if),
        .start(start), .qoff_in(qoff_in), .lat_up(lat_up), .dll_on(dll_on),
        .busy(busy), .done(done), .fail(fail), .locked(locked), .taps(taps));

    wl_dram i_wl_dram (.link(i_wl_link_if), .rst_n(dev_rst_n),
        .nom_en(nom_en), .park_en(park_en), .lvl(lvl), .qoff(qoff),
        .dqs_term(dqs_term), .dq_term(dq_term));

    wl_link_chk i_wl_link_chk (.clk(clk), .rst_n(rst_n),
        .ck(i_wl_link_if.ck), .cmd_mrs(i_wl_link_if.cmd_mrs),
        .cmd_ba(i_wl_link_if.cmd_ba), .cmd_addr(i_wl_link_if.cmd_addr),
        .termination_control_pin(i_wl_link_if.termination_control_pin), .dqs_oe(i_wl_link_if.dqs_oe),
        .dqs_t(i_wl_link_if.dqs_t), .dqs_c(i_wl_link_if.dqs_c),
        .dq(i_wl_link_if.dq), .dq_oe(i_wl_link_if.dq_oe));

    // **************************************************
    // monitors and helpers
    // **************************************************
    // clock level seen at each strobe edge, echoed on the lane
    always @(posedge i_wl_link_if.dqs_t[0]) begin
        smp0 = {smp0[0], i_wl_link_if.ck};
        #1;
        if (i_wl_link_if.dq_oe[0]) check(i_wl_link_if.dq[7:0], {8{smp0[0]}});
    end
    always @(posedge i_wl_link_if.dqs_t[1]) begin
        smp1 = {smp1[0], i_wl_link_if.ck};
        #1;
        if (i_wl_link_if.dq_oe[8]) check(i_wl_link_if.dq[15:8], {8{smp1[0]}});
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return lvl;
            1: return i_wl_link_if.termination_control_pin;
            default: return done;
        endcase
    endfunction

    // bounded wait, leaves us just after a clock edge
    task automatic wait_for(input int k);
        int n;
        n = 0;
        while (sig(k) !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic go(input wl_row_t r);
        {qoff_in, lat_up, dll_on, nom_en, park_en} = {r.qoff, r.lat, r.dll,
            r.nom, r.park};
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
    endtask

    // one complete leveling run for a table row
    task automatic run_row(input wl_row_t r);
        go(r);
        wait_for(0);
        check({lvl, qoff}, {1'b1, r.qoff});
        wait_for(1);
        if (r.lat) check({dqs_term, dq_term}, {r.park, 1'b0});
        repeat (160) @(posedge clk);
        #1;
        check({dqs_term, dq_term}, {r.nom, 1'b0});
        wait_for(2);
        check({busy, lvl, qoff}, 3'h0);
        check(i_wl_link_if.dq_oe, 16'h0000);
        check(locked, r.lock);
        // lock lands half a link period into the sweep, on both lanes
        check(taps, r.qoff ? 6'h00 : 6'h24);
        if (!r.qoff) check({fail, smp0, smp1}, 5'h05);
    endtask

    // **************************************************
    // main sequence
    // **************************************************
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (40) @(posedge clk);
        #1;
        dev_rst_n = 1'b1;
        repeat (24) @(posedge clk);
        #1;
        // ordinary cases from the table
        for (int i = 0; i < 5; i++) begin
            run_row(rows[i]);
            $display("test %0d done", i);
        end
        // reset in the middle of a sweep, then a clean run
        go(7'h1F);
        wait_for(1);
        repeat (600) @(posedge clk);
        #1;
        dev_rst_n = 1'b0;
        repeat (40) @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check({busy, done, i_wl_link_if.termination_control_pin, i_wl_link_if.dqs_oe, lvl}, 6'h00);
        check(i_wl_link_if.dq_oe, 16'h0000);
        rst_n = 1'b1;
        repeat (40) @(posedge clk);
        #1;
        dev_rst_n = 1'b1;
        repeat (24) @(posedge clk);
        #1;
        run_row(rows[3]);
        $display("test reset done");
        test_done();
    end
endmodule
